/* logic/pcsmr_mdio_slave.sv */
// Serial management interface slave that turns frames into requests.
`timescale 1ns/1ns
module pcsmr_mdio_slave (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic [4:0] phy_addr,
  input wire logic [15:0] rd_data,
  output pcsmr_pkg::pcsmr_req_type req,
  output logic mdio_out,
  output logic mdio_oe
);
  import pcsmr_pkg::*;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic mdc_meta_ff, mdc_sync_ff, mdc_prev_ff;
  logic mdio_meta_ff, mdio_sync_ff;
  logic [4:0] pad_meta_ff, pad_sync_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mdc_meta_ff <= 1'h0;
      mdc_sync_ff <= 1'h0;
      mdc_prev_ff <= 1'h0;
      mdio_meta_ff <= 1'h1;
      mdio_sync_ff <= 1'h1;
      pad_meta_ff <= 5'h00;
      pad_sync_ff <= 5'h00;
    end else begin
      mdc_meta_ff <= mdc;
      mdc_sync_ff <= mdc_meta_ff;
      mdc_prev_ff <= mdc_sync_ff;
      mdio_meta_ff <= mdio_in;
      mdio_sync_ff <= mdio_meta_ff;
      pad_meta_ff <= phy_addr;
      pad_sync_ff <= pad_meta_ff;
    end
  end

  // --------------------------------------------------------------------
  // Frame engine
  // --------------------------------------------------------------------
  // The clock is oversampled, so the management clock must stay well below
  // a quarter of the core clock for edges to be seen.
  pcsmr_mf_state_type state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] shift_ff, nxt_shift;
  logic [13:0] hdr_ff, nxt_hdr;
  logic [15:0] out_ff, nxt_out;
  logic rd_act_ff, nxt_rd_act;
  logic mdio_out_ff, nxt_mdio_out;
  logic mdio_oe_ff, nxt_mdio_oe;
  pcsmr_req_type req_ff, nxt_req;
  logic edge_seen;
  logic [13:0] hdr_now;

  assign edge_seen = mdc_sync_ff & ~mdc_prev_ff;
  assign hdr_now = {shift_ff[12:0], mdio_sync_ff};

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_hdr = hdr_ff;
    nxt_out = out_ff;
    nxt_rd_act = rd_act_ff;
    nxt_mdio_out = mdio_out_ff;
    nxt_mdio_oe = mdio_oe_ff;
    nxt_req = '0;
    if (edge_seen) begin
      nxt_shift = {shift_ff[14:0], mdio_sync_ff};
      unique case (state_ff)
        MF_IDLE: begin
          // No preamble is demanded: the first zero bit starts a frame.
          if (!mdio_sync_ff) begin
            nxt_state = MF_FRAME;
            nxt_cnt = 5'h01;
            nxt_rd_act = 1'h0;
          end
        end
        MF_FRAME: begin
          nxt_cnt = cnt_ff + 5'h01;
          if (cnt_ff == MF_REGAD_LAST) begin
            nxt_hdr = hdr_now;
            if (hdr_now[13:12] == MF_START && hdr_now[11:10] == MF_OP_READ
                && hdr_now[9:5] == pad_sync_ff) begin
              nxt_rd_act = 1'h1;
              nxt_req.rd = 1'h1;
              nxt_req.addr = hdr_now[4:0];
            end
          end
          if (rd_act_ff && cnt_ff == MF_TA_FIRST) begin
            nxt_mdio_out = 1'h0;
            nxt_mdio_oe = 1'h1;
            nxt_out = rd_data;
          end
          if (rd_act_ff && cnt_ff > MF_TA_FIRST && cnt_ff <= MF_DATA_LAST)
          begin
            nxt_mdio_out = out_ff[15];
            nxt_out = {out_ff[14:0], 1'h0};
          end
          if (cnt_ff == MF_FRAME_LAST) begin
            nxt_state = MF_IDLE;
            nxt_mdio_oe = 1'h0;
            nxt_mdio_out = 1'h0;
            nxt_rd_act = 1'h0;
            if (hdr_ff[13:12] == MF_START && hdr_ff[11:10] == MF_OP_WRITE
                && hdr_ff[9:5] == pad_sync_ff) begin
              nxt_req.wr = 1'h1;
              nxt_req.addr = hdr_ff[4:0];
              nxt_req.wdata = {shift_ff[14:0], mdio_sync_ff};
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= MF_IDLE;
      cnt_ff <= 5'h00;
      shift_ff <= 16'h0000;
      hdr_ff <= 14'h0000;
      out_ff <= 16'h0000;
      rd_act_ff <= 1'h0;
      mdio_out_ff <= 1'h0;
      mdio_oe_ff <= 1'h0;
      req_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      hdr_ff <= nxt_hdr;
      out_ff <= nxt_out;
      rd_act_ff <= nxt_rd_act;
      mdio_out_ff <= nxt_mdio_out;
      mdio_oe_ff <= nxt_mdio_oe;
      req_ff <= nxt_req;
    end
  end

  assign req = req_ff;
  assign mdio_out = mdio_out_ff;
  assign mdio_oe = mdio_oe_ff;

endmodule

/* logic/pcsmr_pkg.sv */
// Package of constants and carrier types for the PCS management registers.
package pcsmr_pkg;

  // --------------------------------------------------------------------
  // Register addresses
  // --------------------------------------------------------------------
  localparam logic [4:0] REG_CONTROL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h01;

  // --------------------------------------------------------------------
  // Control register field positions
  // --------------------------------------------------------------------
  localparam int CTL_RESET_BIT = 15;
  localparam int CTL_LOOP_BIT = 14;
  localparam int CTL_SPD_LSB_BIT = 13;
  localparam int CTL_AN_EN_BIT = 12;
  localparam int CTL_PDOWN_BIT = 11;
  localparam int CTL_ISO_BIT = 10;
  localparam int CTL_AN_RST_BIT = 9;
  localparam int CTL_DUPLEX_BIT = 8;
  localparam int CTL_COLT_BIT = 7;
  localparam int CTL_SPD_MSB_BIT = 6;
  localparam int CTL_UNIDIR_BIT = 5;

  // Status register field positions.
  localparam int STS_LINK_BIT = 2;

  // Constant read values: duplex and speed MSB in control; extended
  // status, unidirectional, preamble suppression and AN complete in status.
  localparam logic [15:0] CTL_FIXED = 16'h0140;
  localparam logic [15:0] STS_FIXED = 16'h01e0;
  localparam logic [15:0] CTL_RO_MASK = 16'ha1df;
  localparam logic [15:0] STS_RO_MASK = 16'hfffb;

  // --------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------
  localparam logic LOOP_RST = 1'h0;
  localparam logic AN_EN_RST = 1'h1;
  localparam logic PDOWN_RST = 1'h0;
  localparam logic ISO_RST = 1'h1;
  localparam logic AN_RST_RST = 1'h0;
  localparam logic UNIDIR_RST = 1'h0;
  localparam logic LINK_RST = 1'h0;

  // --------------------------------------------------------------------
  // Management frame layout
  // --------------------------------------------------------------------
  localparam logic [1:0] MF_START = 2'h1;
  localparam logic [1:0] MF_OP_READ = 2'h2;
  localparam logic [1:0] MF_OP_WRITE = 2'h1;
  localparam logic [4:0] MF_REGAD_LAST = 5'h0d;
  localparam logic [4:0] MF_TA_FIRST = 5'h0e;
  localparam logic [4:0] MF_DATA_LAST = 5'h1e;
  localparam logic [4:0] MF_FRAME_LAST = 5'h1f;

  // --------------------------------------------------------------------
  // Carrier types
  // --------------------------------------------------------------------
  typedef struct packed {
    logic loopback;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic an_restart;
    logic unidir;
  } pcsmr_ctrl_type;

  localparam pcsmr_ctrl_type CTRL_RESET = '{
    loopback: LOOP_RST, an_enable: AN_EN_RST, power_down: PDOWN_RST,
    isolate: ISO_RST, an_restart: AN_RST_RST, unidir: UNIDIR_RST};

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } pcsmr_req_type;

  typedef enum logic [0:0] {
    MF_IDLE = 1'b0,
    MF_FRAME = 1'b1
  } pcsmr_mf_state_type;

endpackage

/* logic/pcsmr_regs.sv */
// Management control and status registers of a 1000BASE-X PCS.
// Functional notes
// - Writing one to the reset bit resets the PCS; the bit self-clears.
// - Loopback bit loops transmit to receive inside the transceiver build.
// - In the ten-bit build the loopback bit drives the wrap request out.
// - Speed bits read constant: low bit zero, high bit one, 1000 Mb/s.
// - Negotiation enable and restart bits are read/write, with no effect.
// - Transceiver power-down is set by writing; only a reset clears it.
// - In the ten-bit build the power-down bit is stored without effect.
// - Isolate bit, default one, isolates the PHY from the GMII.
// - Duplex bit reads one; collision test bit reads zero.
// - Unidirectional bit, reset zero, transmits regardless of receive.
// - Control bits four to zero read zero; writes to them are dropped.
// - Status bits fifteen to nine read zero.
// - Extended status indication bit reads one.
// - Unidirectional ability bit reads one; writes ignored.
// - Preamble suppression bit reads one.
// - Negotiation complete reads one; remote fault and ability read zero.
// - Link status latches low on link loss; a read reloads it.
// - Link status one means link held valid since the last read.
// - Jabber detect and extended capability bits read zero.
// - Undefined addresses read zero and ignore writes.
// - Reset input, clock manager lock loss and soft reset restore defaults.
`timescale 1ns/1ns
module pcsmr_regs #(
  parameter bit USE_XCVR = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clock_manager_locked,
  input wire logic link_ok,
  input wire logic mdc,
  input wire logic mdio_in,
  input wire logic [4:0] phy_addr,
  output logic mdio_out,
  output logic mdio_oe,
  output logic pcs_reset,
  output logic loopback_internal,
  output logic ewrap,
  output logic xcvr_powerdown,
  output logic isolate,
  output logic unidir_enable
);
  import pcsmr_pkg::*;

  // --------------------------------------------------------------------
  // Management frame slave
  // --------------------------------------------------------------------
  pcsmr_req_type req;
  logic [15:0] rd_data_ff, nxt_rd_data;

  pcsmr_mdio_slave pcsmr_mdio_slave_i (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .phy_addr(phy_addr),
    .rd_data(rd_data_ff),
    .req(req),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe)
  );

  // --------------------------------------------------------------------
  // Lock synchroniser
  // --------------------------------------------------------------------
  logic lock_meta_ff, lock_sync_ff;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lock_meta_ff <= 1'h0;
      lock_sync_ff <= 1'h0;
    end else begin
      lock_meta_ff <= clock_manager_locked;
      lock_sync_ff <= lock_meta_ff;
    end
  end

  // --------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------
  pcsmr_ctrl_type ctrl_ff, nxt_ctrl;
  logic pcs_reset_ff, nxt_pcs_reset;
  logic wr_ctrl, rd_status, soft_reset, clear_all;

  assign wr_ctrl = req.wr && (req.addr == REG_CONTROL);
  assign rd_status = req.rd && (req.addr == REG_STATUS);
  assign soft_reset = wr_ctrl && req.wdata[CTL_RESET_BIT];
  assign clear_all = !lock_sync_ff || soft_reset;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_pcs_reset = 1'h0;
    if (clear_all) begin
      // The reset bit is never stored, so it reads back zero.
      nxt_ctrl = CTRL_RESET;
      nxt_pcs_reset = 1'h1;
    end else if (wr_ctrl) begin
      nxt_ctrl.loopback = req.wdata[CTL_LOOP_BIT];
      nxt_ctrl.an_enable = req.wdata[CTL_AN_EN_BIT];
      nxt_ctrl.an_restart = req.wdata[CTL_AN_RST_BIT];
      // A written zero cannot lift power-down; only a reset does.
      nxt_ctrl.power_down = ctrl_ff.power_down |
                            req.wdata[CTL_PDOWN_BIT];
      nxt_ctrl.isolate = req.wdata[CTL_ISO_BIT];
      nxt_ctrl.unidir = req.wdata[CTL_UNIDIR_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= CTRL_RESET;
      pcs_reset_ff <= 1'h1;
    end else begin
      ctrl_ff <= nxt_ctrl;
      pcs_reset_ff <= nxt_pcs_reset;
    end
  end

  // --------------------------------------------------------------------
  // Latched link status
  // --------------------------------------------------------------------
  logic link_latch_ff, nxt_link_latch;

  always_comb begin
    // A loss in the same cycle as a read is kept, since the reload takes
    // the present link value.
    nxt_link_latch = link_latch_ff & link_ok;
    if (rd_status) begin
      nxt_link_latch = link_ok;
    end
    if (clear_all) begin
      nxt_link_latch = LINK_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      link_latch_ff <= LINK_RST;
    end else begin
      link_latch_ff <= nxt_link_latch;
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  logic [15:0] ctl_word, sts_word;

  always_comb begin
    // Constant fields come only from the fixed words, so writes to them
    // are lost by construction.
    ctl_word = CTL_FIXED;
    ctl_word[CTL_LOOP_BIT] = ctrl_ff.loopback;
    ctl_word[CTL_AN_EN_BIT] = ctrl_ff.an_enable;
    ctl_word[CTL_PDOWN_BIT] = ctrl_ff.power_down;
    ctl_word[CTL_ISO_BIT] = ctrl_ff.isolate;
    ctl_word[CTL_AN_RST_BIT] = ctrl_ff.an_restart;
    ctl_word[CTL_UNIDIR_BIT] = ctrl_ff.unidir;
    sts_word = STS_FIXED;
    sts_word[STS_LINK_BIT] = link_latch_ff;
    nxt_rd_data = rd_data_ff;
    if (req.rd) begin
      unique case (req.addr)
        REG_CONTROL: nxt_rd_data = ctl_word;
        REG_STATUS: nxt_rd_data = sts_word;
        default: nxt_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_ff <= 16'h0000;
    end else begin
      rd_data_ff <= nxt_rd_data;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // The build choice only steers which flip-flop reaches which pin.
  assign pcs_reset = pcs_reset_ff;
  assign loopback_internal = USE_XCVR ? ctrl_ff.loopback : 1'b0;
  assign ewrap = USE_XCVR ? 1'b0 : ctrl_ff.loopback;
  assign xcvr_powerdown = USE_XCVR ? ctrl_ff.power_down : 1'b0;
  assign isolate = ctrl_ff.isolate;
  assign unidir_enable = ctrl_ff.unidir;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_SOFT_RESET: assert property (
    soft_reset && lock_sync_ff |=> pcs_reset && ctrl_ff == CTRL_RESET
      && !link_latch_ff ##1 !pcs_reset || !lock_sync_ff)
    else $error("soft reset did not restore defaults for one cycle");

  AST_LOCK_LOSS: assert property (
    !lock_sync_ff |=> ctrl_ff == CTRL_RESET && pcs_reset && !link_latch_ff)
    else $error("lock loss did not restore defaults");

  AST_LOOP_PATH: assert property (
    wr_ctrl && !clear_all |=> (USE_XCVR ? loopback_internal : ewrap)
      == $past(req.wdata[CTL_LOOP_BIT]) && !(USE_XCVR ? ewrap
      : loopback_internal))
    else $error("loopback write did not reach the right output");

  AST_PDOWN_STICKY: assert property (
    $fell(ctrl_ff.power_down) |-> $past(clear_all))
    else $error("power-down cleared without a reset");

  AST_PDOWN_TBI: assert property (
    !USE_XCVR |-> !xcvr_powerdown)
    else $error("power-down acted in the ten-bit build");

  AST_CTRL_WRITE: assert property (
    wr_ctrl && !clear_all |=> unidir_enable == $past(req.wdata[CTL_UNIDIR_BIT])
      && isolate == $past(req.wdata[CTL_ISO_BIT])
      && ctrl_ff.an_enable == $past(req.wdata[CTL_AN_EN_BIT]))
    else $error("control write not stored");

  AST_CTRL_CONST: assert property (
    req.rd && req.addr == REG_CONTROL |=>
      (rd_data_ff & CTL_RO_MASK) == CTL_FIXED)
    else $error("control constant bits read wrong");

  AST_STATUS_CONST: assert property (
    req.rd && req.addr == REG_STATUS |=>
      (rd_data_ff & STS_RO_MASK) == STS_FIXED
      && rd_data_ff[STS_LINK_BIT] == $past(link_latch_ff))
    else $error("status read wrong");

  AST_UNDEF_ZERO: assert property (
    req.rd && req.addr != REG_CONTROL && req.addr != REG_STATUS
      |=> rd_data_ff == 16'h0000)
    else $error("undefined address read nonzero");

  AST_UNDEF_WRITE: assert property (
    req.wr && req.addr != REG_CONTROL && lock_sync_ff |=> $stable(ctrl_ff))
    else $error("undefined address write changed control");

  AST_LINK_DROP: assert property (
    !link_ok |=> !link_latch_ff ##1 (!link_latch_ff || $past(rd_status)))
    else $error("link loss not latched until read");

  AST_LINK_RISE: assert property (
    $rose(link_latch_ff) |-> $past(rd_status) && $past(link_ok))
    else $error("link status rose without a read of an up link");

  // A core reset output that lingers would hold the PCS down after its
  // cause is gone, so the pulse must end as soon as the cause does.
  AST_RESET_SELF_CLEAR: assert property (
    !clear_all |=> !pcs_reset)
    else $error("core reset output stayed high without a cause");

  AST_RESET_BIT_ZERO: assert property (
    req.rd && req.addr == REG_CONTROL |=> !rd_data_ff[CTL_RESET_BIT])
    else $error("control reset bit read back as one");

  AST_ISO_DEFAULT: assert property (
    clear_all |=> isolate && !unidir_enable && !loopback_internal && !ewrap)
    else $error("reset left isolate or loopback in the wrong state");

  AST_AN_STORE: assert property (
    wr_ctrl && !clear_all |=> ctrl_ff.an_restart
      == $past(req.wdata[CTL_AN_RST_BIT]))
    else $error("negotiation restart bit not stored");

  AST_PDOWN_HOLD: assert property (
    ctrl_ff.power_down && !clear_all |=> ctrl_ff.power_down
      && xcvr_powerdown == USE_XCVR)
    else $error("power-down lost without a reset");

  AST_PDOWN_SET: assert property (
    wr_ctrl && !clear_all && req.wdata[CTL_PDOWN_BIT]
      |=> ctrl_ff.power_down)
    else $error("power-down write not stored");

  AST_STATUS_WRITE: assert property (
    req.wr && req.addr == REG_STATUS && !clear_all |=>
      $stable(ctrl_ff) && link_latch_ff == $past(link_latch_ff & link_ok))
    else $error("status write changed register state");

  AST_LINK_READ_UP: assert property (
    rd_status && !clear_all |=> link_latch_ff == $past(link_ok))
    else $error("status read did not reload the link state");

  AST_WRAP_LEVEL: assert property (
    !USE_XCVR |-> ewrap == ctrl_ff.loopback && !loopback_internal)
    else $error("wrap request does not follow the loopback bit");

  COV_SOFT_RESET: cover property (soft_reset && lock_sync_ff);
  COV_STATUS_UP: cover property (rd_status ##1 rd_data_ff[STS_LINK_BIT]);
  COV_LINK_LATCH: cover property (link_latch_ff ##1 !link_latch_ff
    ##[1:200] rd_status);
  COV_PDOWN: cover property (wr_ctrl && req.wdata[CTL_PDOWN_BIT]
    && !req.wdata[CTL_RESET_BIT]);

endmodule

/* testbench/pcsmr_regs_tb_top.sv */
// Self-checking bench for the PCS management registers, both builds.
`timescale 1ns/1ns
module pcsmr_regs_tb_top;
  import pcsmr_pkg::*;
  localparam logic [4:0] PA = 5'h05;
  localparam logic [4:0] PB = 5'h0a;
  logic ref_clk, rstn, lock, link_ok, mdc, st_bit, st_oe, line;
  logic [4:0] pa, pb;
  logic oe_a, out_a, rst_a, lb_a, wr_a, pd_a, iso_a, ud_a;
  logic oe_b, out_b, rst_b, lb_b, wr_b, pd_b, iso_b, ud_b;
  logic [15:0] rd;
  int err_count, cmp_count, rst_cycles;

  // The line has a pull-up; with several enables high, the transceiver build beats the ten-bit build, which beats the station.
  assign line = oe_a ? out_a : (oe_b ? out_b : (st_oe ? st_bit : 1'b1));

  pcsmr_station pcsmr_station_i (.ref_clk(ref_clk), .mdio_line(line),
    .mdc(mdc), .st_bit(st_bit), .st_oe(st_oe));
  pcsmr_regs #(.USE_XCVR(1'b1)) pcsmr_regs_i (.ref_clk(ref_clk),
    .rstn(rstn), .clock_manager_locked(lock), .link_ok(link_ok),
    .mdc(mdc), .mdio_in(line), .phy_addr(pa), .mdio_out(out_a),
    .mdio_oe(oe_a), .pcs_reset(rst_a), .loopback_internal(lb_a),
    .ewrap(wr_a), .xcvr_powerdown(pd_a), .isolate(iso_a),
    .unidir_enable(ud_a));
  // Ten-bit build shares the bus under a second address.
  pcsmr_regs #(.USE_XCVR(1'b0)) pcsmr_regs_tbi_i (.ref_clk(ref_clk),
    .rstn(rstn), .clock_manager_locked(lock), .link_ok(link_ok),
    .mdc(mdc), .mdio_in(line), .phy_addr(pb), .mdio_out(out_b),
    .mdio_oe(oe_b), .pcs_reset(rst_b), .loopback_internal(lb_b),
    .ewrap(wr_b), .xcvr_powerdown(pd_b), .isolate(iso_b),
    .unidir_enable(ud_b));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (rst_a === 1'b1) begin
      rst_cycles <= rst_cycles + 1;
    end
  end

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp=%h seen=%h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] phy, input logic [4:0] a,
                    input logic [15:0] d);
    logic [15:0] x;
    pcsmr_station_i.xfer(MF_OP_WRITE, phy, a, d, x);
  endtask

  task automatic rchk(input logic [4:0] phy, input logic [4:0] a,
                      input logic [15:0] exp, input string name);
    pcsmr_station_i.xfer(MF_OP_READ, phy, a, 16'h0000, rd);
    check(name, rd, exp);
  endtask

  // Order: pcs_reset, loopback, ewrap, powerdown, isolate, unidir.
  task automatic outs(input logic [15:0] exp_a, input logic [15:0] exp_b);
    check("outs_a", {10'h000, rst_a, lb_a, wr_a, pd_a, iso_a, ud_a}, exp_a);
    check("outs_b", {10'h000, rst_b, lb_b, wr_b, pd_b, iso_b, ud_b}, exp_b);
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_defaults();
    outs(16'h0002, 16'h0002);
    rchk(PA, REG_CONTROL, 16'h1540, "ctl_rst");
    rchk(PB, REG_CONTROL, 16'h1540, "ctl_rst_b");
    rchk(PA, REG_STATUS, 16'h01e0, "sts_first");
    rchk(PA, REG_STATUS, 16'h01e4, "sts_up");
  endtask

  task automatic t_write();
    wr(PA, REG_CONTROL, 16'h7fff);
    rchk(PA, REG_CONTROL, 16'h5f60, "ctl_ones");
    outs(16'h0017, 16'h0002);
    wr(PA, REG_CONTROL, 16'h0000);
    rchk(PA, REG_CONTROL, 16'h0940, "ctl_zero");
    outs(16'h0004, 16'h0002);
    wr(PB, REG_CONTROL, 16'h7fff);
    rchk(PB, REG_CONTROL, 16'h5f60, "ctl_tbi");
    outs(16'h0004, 16'h000b);
  endtask

  task automatic t_soft();
    int c0;
    c0 = rst_cycles;
    // Loopback set in the same write must be dropped by the reset.
    wr(PA, REG_CONTROL, 16'hc000);
    check("rst_pulse", 16'(rst_cycles - c0), 16'h0001);
    rchk(PA, REG_CONTROL, 16'h1540, "ctl_soft");
    rchk(PA, REG_STATUS, 16'h01e0, "sts_soft");
    outs(16'h0002, 16'h000b);
  endtask

  task automatic t_link();
    rchk(PA, REG_STATUS, 16'h01e4, "sts_reload");
    link_ok <= 1'b0;
    repeat (2) @(posedge ref_clk);
    link_ok <= 1'b1;
    rchk(PA, REG_STATUS, 16'h01e0, "sts_glitch");
    rchk(PA, REG_STATUS, 16'h01e4, "sts_again");
    link_ok <= 1'b0;
    rchk(PA, REG_STATUS, 16'h01e0, "sts_down");
    rchk(PA, REG_STATUS, 16'h01e0, "sts_still");
    link_ok <= 1'b1;
  endtask

  task automatic t_undef();
    logic [4:0] ads[4];
    ads = '{5'h02, 5'h03, 5'h0f, 5'h1f};
    wr(PA, REG_STATUS, 16'hffff);
    rchk(PA, REG_STATUS, 16'h01e0, "sts_wr");
    foreach (ads[i]) begin
      wr(PA, ads[i], 16'hffff);
      rchk(PA, ads[i], 16'h0000, "undef");
    end
  endtask

  task automatic t_refuse();
    logic [15:0] x;
    pcsmr_station_i.xfer(2'h3, PA, REG_CONTROL, 16'h4000, x);
    wr(5'h1f, REG_CONTROL, 16'h4000);
    pcsmr_station_i.xfer(MF_OP_READ, 5'h1f, REG_CONTROL, 16'h0000, rd);
    check("no_answer", rd, 16'hffff);
    rchk(PA, REG_CONTROL, 16'h1540, "ctl_refused");
  endtask

  task automatic t_resets();
    wr(PA, REG_CONTROL, 16'h7fff);
    lock <= 1'b0;
    repeat (6) @(posedge ref_clk);
    check("rst_lock", {15'h0000, rst_a}, 16'h0001);
    lock <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rchk(PA, REG_CONTROL, 16'h1540, "ctl_lock");
    rchk(PB, REG_CONTROL, 16'h1540, "ctl_lock_b");
    wr(PA, REG_CONTROL, 16'h7fff);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rchk(PA, REG_CONTROL, 16'h1540, "ctl_rstn");
    rchk(PA, REG_STATUS, 16'h01e0, "sts_rstn");
  endtask

  task automatic conclude();
    if (err_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    err_count = 0;
    cmp_count = 0;
    rstn = 1'b0;
    lock = 1'b1;
    link_ok = 1'b1;
    pa = PA;
    pb = PB;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    t_defaults();
    t_write();
    t_soft();
    t_link();
    t_undef();
    t_refuse();
    t_resets();
    conclude();
  end

  // About forty frames of some 330 cycles each fit well inside this span.
  initial begin
    #400000;
    err_count++;
    conclude();
  end
endmodule

/* testbench/pcsmr_station.sv */
// Management station model that drives frames onto the shared data line.
`timescale 1ns/1ns
module pcsmr_station (
  input wire logic ref_clk,
  input wire logic mdio_line,
  output logic mdc,
  output logic st_bit,
  output logic st_oe
);
  initial begin
    mdc = 1'b0;
    st_bit = 1'b1;
    st_oe = 1'b0;
  end

  // --------------------------------------------------------------------
  // Frame transfer
  // --------------------------------------------------------------------
  // Each clock phase lasts five core cycles, above the two the slave's
  // oversampler needs. The clock stands low between frames. On a read
  // the line is released from the turnaround on, so an absent answer
  // shows as the pull-up level rather than a stale bit.
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy,
                      input logic [4:0] reg_a, input logic [15:0] wd,
                      output logic [15:0] rd);
    logic [31:0] frm;
    frm = {2'h1, op, phy, reg_a, 2'h2, wd};
    rd = 16'h0000;
    @(posedge ref_clk);
    for (int i = 0; i < 32; i++) begin
      mdc <= 1'b0;
      st_oe <= (op != 2'h2) || (i < 14);
      st_bit <= frm[31 - i];
      repeat (5) @(posedge ref_clk);
      mdc <= 1'b1;
      if (i >= 16) begin
        rd[31 - i] = mdio_line;
      end
      repeat (5) @(posedge ref_clk);
    end
    mdc <= 1'b0;
    st_oe <= 1'b0;
    st_bit <= 1'b1;
    repeat (10) @(posedge ref_clk);
  endtask
endmodule
